/* logic/brbc_pkg.sv */
/*
 * brbc_pkg: shared constants and carriers for the board reset and boot
 * control block.
 * Assumes a 32-bit AXI4-Lite register bus clocked by aclk at 125 MHz.
 */
package brbc_pkg;

  localparam logic [31:0] BRBC_SWRST_ADDR   = 32'hF0FF_A000;
  localparam logic [31:0] BRBC_STATUS_ADDR  = 32'hF0FF_A004;
  localparam logic [31:0] BRBC_LED_ADDR     = 32'hF0FF_A008;
  localparam logic [31:0] BRBC_TRIGGER_VAL  = 32'h0000_0001;
  localparam logic [31:0] BRBC_CONSOLE_ADDR = 32'hF0FF_A00C;

  // status word field positions
  localparam int BRBC_ST_BOOT_BIT = 0;
  localparam int BRBC_ST_HOLD_BIT = 1;
  localparam int BRBC_ST_DONE_BIT = 2;

  // console format word: baud in bits 23:0, data bits 27:24, stop 31:28
  localparam logic [23:0] BRBC_BAUD      = 24'h01_C200;
  localparam logic [3:0]  BRBC_DATA_BITS = 4'h8;
  localparam logic [3:0]  BRBC_STOP_BITS = 4'h1;

  localparam logic        BRBC_LED_RST   = 1'b0;
  localparam int          BRBC_RST_PULSE_NS = 1000;
  localparam int          BRBC_CLK_NS       = 8;
  localparam int          BRBC_RST_CYCLES   =
    (BRBC_RST_PULSE_NS + BRBC_CLK_NS - 1) / BRBC_CLK_NS;

  localparam logic [1:0]  BRBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BRBC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic boot_select_jumper;
    logic config_hold_jumper;
    logic config_done;
  } brbc_straps_t;

  typedef struct packed {
    logic board_reset_n;
    logic reload_request;
  } brbc_reset_out_t;

endpackage : brbc_pkg

/* logic/brbc_top.sv */
/*
 * brbc_top: AXI4-Lite slave holding the software reset trigger, the jumper
 * status word, the user LED control and the fixed console format.
 * Assumes the configuration controller acts on reload_request and that
 * jumper inputs are already synchronous to aclk.
 */
`timescale 1ns/1ps

// Overview of operation
// - software reset reloads FPGA, resets all ICs
// - write 0x1 at reset word triggers reset (full-word write only)
// - boot select jumper readable by software
// - hold jumper shorted stops configuration at power-on
// - controller programs flash, configures on restart
// - whole flash readable and writable by processor
// - user LED lights on low output
// - console 115200 baud, 8 data, 1 stop
module brbc_top
  import brbc_pkg::*;
#(
  parameter int RST_CYCLES = BRBC_RST_CYCLES
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire brbc_straps_t  straps,
  output brbc_reset_out_t    reset_out,
  output logic               config_enable,
  output logic               user_indicator_led_n
);

  // one-hot so each output decode is a single state bit
  typedef enum logic [2:0] {
    BRBC_IDLE  = 3'b001,
    BRBC_PULSE = 3'b010,
    BRBC_WAIT  = 3'b100
  } brbc_state_t;

  logic [31:0]  awaddr_q, awaddr_d;
  logic         aw_have_q, aw_have_d;
  logic [31:0]  wdata_q, wdata_d;
  logic [3:0]   wstrb_q, wstrb_d;
  logic         w_have_q, w_have_d;
  logic         bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d;
  logic         rvalid_q, rvalid_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [1:0]   rresp_q, rresp_d;
  logic         led_q, led_d;
  logic         hold_q, hold_d;
  logic         hold_taken_q;
  brbc_state_t  state_q, state_d;
  logic [15:0]  cnt_q, cnt_d;

  // prot bits are ignored: these words grant no privileged access
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire [31:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws = w_have_q ? wstrb_q : s_axi_wstrb;
  wire aw_ok = aw_have_q || s_axi_awvalid;
  wire w_ok  = w_have_q || s_axi_wvalid;
  // one write at a time: the response must drain before the next
  wire wr_do = aw_ok && w_ok && !bvalid_q;
  wire wr_rst = wr_do && (wa == BRBC_SWRST_ADDR);
  wire wr_led = wr_do && (wa == BRBC_LED_ADDR);
  // only a full-word write of exactly the trigger value fires
  wire fire   = wr_rst && (ws == 4'hF)
                && (wd == BRBC_TRIGGER_VAL);
  wire wr_map = wr_rst || wr_led;
  wire [31:0] status_word = {29'h0, straps.config_done,
                             hold_q, straps.boot_select_jumper};
  wire [31:0] console_word = {BRBC_STOP_BITS, BRBC_DATA_BITS,
                              BRBC_BAUD};
  wire rd_status  = s_axi_araddr == BRBC_STATUS_ADDR;
  wire rd_led     = s_axi_araddr == BRBC_LED_ADDR;
  wire rd_console = s_axi_araddr == BRBC_CONSOLE_ADDR;
  wire rd_swrst   = s_axi_araddr == BRBC_SWRST_ADDR;
  // flash window is left to its own decoder, none of it is claimed here
  wire rd_map = rd_status || rd_led || rd_console || rd_swrst;
  // reset word is write-only and reads back as zero
  wire [31:0] rd_word = rd_status  ? status_word :
                        rd_led     ? {31'h0, led_q} :
                        rd_console ? console_word : 32'h0;

  // ready drops while a half is held or a response waits
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    awaddr_d  = aw_take ? s_axi_awaddr : awaddr_q;
    aw_have_d = (aw_have_q || aw_take) && !wr_do;
    wdata_d   = w_take ? s_axi_wdata : wdata_q;
    wstrb_d   = w_take ? s_axi_wstrb : wstrb_q;
    w_have_d  = (w_have_q || w_take) && !wr_do;
    bvalid_d  = wr_do || (bvalid_q && !s_axi_bready);
    // unmapped words answer with an error rather than a silent drop
    bresp_d   = wr_do ? (wr_map ? BRBC_RESP_OKAY : BRBC_RESP_SLVERR)
                      : bresp_q;
    rvalid_d  = ar_take || (rvalid_q && !s_axi_rready);
    // read word held in flops until the master takes it
    rdata_d   = ar_take ? rd_word : rdata_q;
    rresp_d   = ar_take ? (rd_map ? BRBC_RESP_OKAY : BRBC_RESP_SLVERR)
                        : rresp_q;
    led_d     = (wr_led && ws[0]) ? wd[0] : led_q;
    hold_d    = hold_taken_q ? hold_q : straps.config_hold_jumper;
  end

  // reset pulse sequencer; count loads on entry only, so a
  // trigger during the pulse cannot stretch it
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      BRBC_IDLE: begin
        if (fire) begin
          state_d = BRBC_PULSE;
          cnt_d   = 16'(RST_CYCLES);
        end
      end
      BRBC_PULSE: begin
        if (cnt_q <= 16'h1) begin
          state_d = BRBC_WAIT;
        end else begin
          cnt_d = cnt_q - 16'h1;
        end
      end
      // the board reset also clears us; stay parked until it does
      BRBC_WAIT: state_d = BRBC_WAIT;
      default: state_d = BRBC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      led_q     <= BRBC_LED_RST;
      state_q   <= BRBC_IDLE;
      cnt_q     <= 16'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      led_q     <= led_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
    end
  end

  // strap caught once after reset release
  // later jumper moves must not stop a configuration already running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_taken_q <= 1'b0;
      hold_q       <= 1'b0;
    end else begin
      hold_taken_q <= 1'b1;
      hold_q       <= hold_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 32'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bresp_q  <= 2'h0;
      rdata_q  <= 32'h0;
      rresp_q  <= 2'h0;
    end else begin
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bresp_q  <= bresp_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // reload and board reset share one pulse so every IC sees the restart
  assign reset_out = '{board_reset_n:  (state_q != BRBC_PULSE),
                       reload_request: (state_q == BRBC_PULSE)};
  // configuration runs unless the hold strap was caught shorted after reset release
  assign config_enable = !hold_q;
  // led bit 1 means lit; pin is low to light
  assign user_indicator_led_n = !led_q;

endmodule // brbc_top

/* sim/brbc_cfg_model.sv */
/* brbc_cfg_model: configuration controller stand-in.
   Assumes reload_request is synchronous to aclk. */
`timescale 1ns/1ps
module brbc_cfg_model #(parameter int LOAD_CYCLES = 6) (
  input  wire logic aclk, reload_request,
  output wire logic config_done
);
  int cnt_q = 0;
  // flash read outlasts the pulse, so done lags the reset
  always @(posedge aclk)
    cnt_q <= reload_request ? LOAD_CYCLES : cnt_q - int'(cnt_q > 0);
  assign config_done = (cnt_q == 0);
endmodule // brbc_cfg_model

/* sim/brbc_chk.sv */
/* brbc_chk: port checks of reset pulse, straps, LED and format word.
   Assumes address and data of a write are offered together. */
`timescale 1ns/1ps
module brbc_chk
  import brbc_pkg::*;
#(parameter int RST_CYCLES = BRBC_RST_CYCLES) (
  input wire logic aclk, aresetn, config_enable, user_indicator_led_n,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_arvalid, s_axi_arready,
  input wire logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire brbc_straps_t straps,
  input wire brbc_reset_out_t reset_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic wt_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                    && s_axi_wready;
  wire logic sw_w = wt_w && s_axi_awaddr == BRBC_SWRST_ADDR;
  wire logic go_w = sw_w && s_axi_wdata == BRBC_TRIGGER_VAL
                    && s_axi_wstrb == 4'hF;
  wire logic st_w = s_axi_arvalid && s_axi_arready;
  wire logic rr_w = reset_out.reload_request;
  int cnt_q;
  always_ff @(posedge aclk) cnt_q <= (aresetn && rr_w) ? cnt_q + 1 : 0;
  sequence s_pulse; rr_w && !reset_out.board_reset_n; endsequence
  property p_go; go_w |-> ##[1:8] s_pulse; endproperty
  a_go: assert property (p_go) else $error("no pulse");
  property p_only; sw_w && !go_w && !rr_w |=> !rr_w [*4]; endproperty
  a_only: assert property (p_only) else $error("stray pulse");
  property p_brd; rr_w == !reset_out.board_reset_n; endproperty
  a_brd: assert property (p_brd) else $error("board reset");
  property p_len; $fell(rr_w) |-> cnt_q == RST_CYCLES; endproperty
  a_len: assert property (p_len) else $error("pulse length");
  property p_led; wt_w && s_axi_awaddr == BRBC_LED_ADDR && s_axi_wstrb[0]
    |=> user_indicator_led_n == !$past(s_axi_wdata[0]); endproperty
  a_led: assert property (p_led) else $error("led level");
  property p_boot; st_w && s_axi_araddr == BRBC_STATUS_ADDR |=>
    s_axi_rdata[1:0] == {!config_enable, $past(straps.boot_select_jumper)};
  endproperty
  a_boot: assert property (p_boot) else $error("status");
  property p_fmt; st_w && s_axi_araddr == BRBC_CONSOLE_ADDR |=>
    s_axi_rdata == 32'h1801_C200; endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_hold; $rose(aresetn)
    |=> config_enable == !$past(straps.config_hold_jumper); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // brbc_chk
bind brbc_top brbc_chk #(.RST_CYCLES(RST_CYCLES)) chk_u (.*);

/* sim/brbc_top_bench.sv */
/* brbc_top_bench: register-level test of the reset and boot block.
   Assumes the bound checker and the controller model. */
`timescale 1ns/1ps
module brbc_top_bench;
  import brbc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, boot = 1'b1, hold = 1'b0, done;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, user_indicator_led_n;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rd;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic config_enable;
  brbc_straps_t straps;
  brbc_reset_out_t reset_out;
  int fail_count = 0, checks_done = 0, n;
  assign straps = '{boot, hold, done};
  brbc_top #(.RST_CYCLES(4)) dut_u (.*);
  brbc_cfg_model cfg_u (.aclk(aclk), .config_done(done),
    .reload_request(reset_out.reload_request));
  initial forever #4 aclk = ~aclk;
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) $display("BAD t=%0t got %h exp %h", $time, g, e);
    if (g !== e) fail_count++;
  endtask
  // one transfer; guards keep each valid to a single update per edge
  task xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    rd = w ? 32'(s_axi_bresp) : s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    if (n < 50) return;
    fail_count++;
    end_of_test();
  endtask
  task rst(input logic b, input logic h);
    {aresetn, boot, hold} <= {1'b0, b, h};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    rst(1'b1, 1'b0);
    chk(32'(config_enable), 32'h1);
    xf(1'b0, BRBC_STATUS_ADDR, '0);
    chk(rd, 32'h5);
    chk(32'(rs), 32'(BRBC_RESP_OKAY));
    xf(1'b0, BRBC_CONSOLE_ADDR, '0);
    chk(rd, 32'h1801_C200);
    xf(1'b1, 32'hF0FF_A010, '0);
    chk(rd, 32'(BRBC_RESP_SLVERR));
    xf(1'b0, 32'hF0FF_A010, '0);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(BRBC_RESP_SLVERR));
    for (int i = 0; i < 2; i++) begin
      xf(1'b1, BRBC_LED_ADDR, 32'(1 - i));
      chk(32'(user_indicator_led_n), 32'(i));
      xf(1'b0, BRBC_LED_ADDR, '0);
      chk(rd, 32'(1 - i));
    end
    xf(1'b1, BRBC_SWRST_ADDR, 32'h2);
    chk(rd, 32'(BRBC_RESP_OKAY));
    s_axi_wstrb <= 4'h1;
    xf(1'b1, BRBC_SWRST_ADDR, BRBC_TRIGGER_VAL);
    s_axi_wstrb <= 4'hF;
    xf(1'b0, BRBC_SWRST_ADDR, '0);
    chk({rd[31:2], reset_out}, 32'h2);
    xf(1'b1, BRBC_SWRST_ADDR, BRBC_TRIGGER_VAL);
    for (n = 0; n < 50 && !reset_out.reload_request; n++) @(posedge aclk);
    chk(32'(reset_out), 32'h1);
    for (n = 0; n < 50 && reset_out.reload_request; n++) @(posedge aclk);
    chk(32'(n), 32'h4);
    for (n = 0; n < 50 && !done; n++) @(posedge aclk);
    chk(32'(done), 32'h1);
    rst(1'b0, 1'b1);
    chk(32'(config_enable), 32'h0);
    chk(32'(user_indicator_led_n), 32'h1);
    chk(32'(reset_out), 32'h2);
    xf(1'b0, BRBC_STATUS_ADDR, '0);
    chk(rd, 32'h6);
    end_of_test();
  end
endmodule // brbc_top_bench
